/* pcrc_top.sv */
// Programmable CRC engine with AHB-Lite register slave
`include "pcrc_cfg.svh"
module pcrc_top #(
  parameter int DEPTH = 16,  // FIFO words, power of two
  parameter int CW    = 5    // Word count width
) (
  input  wire logic                  core_clk,   // 10 MHz clock
  input  wire logic                  rst,        // Async reset
  input  wire logic                  hsel,       // Slave select
  input  wire logic [31:0]           haddr,      // Byte address
  input  wire logic [1:0]            htrans,     // Transfer type
  input  wire logic                  hwrite,     // Write not read
  input  wire logic [2:0]            hsize,      // Word only
  input  wire pcrc_pkg::pcrc_word_t  hwdata,     // Write data
  input  wire logic                  hready,     // Bus ready
  output logic                       hreadyout,  // Slave ready
  output pcrc_pkg::pcrc_word_t       hrdata,     // Read data
  output logic                       hresp,      // Always OKAY
  output logic                       irq         // Level interrupt
);
  import pcrc_pkg::*;

  pcrc_fifo_if #(.CW(CW)) fif ();

  // Control and configuration state
  logic          moduleEnableBit;
  logic          calcGo;
  logic          lsbFirstSelect;
  logic          irqConditionSelect;
  pcrc_len_t     dataWordWidth;
  pcrc_len_t     polyLength;
  logic [15:0]   polyTermsLow;
  logic [15:0]   polyTermsHigh;
  logic [15:0]   dataInLow;
  logic [15:0]   dataInHigh;
  pcrc_word_t    result;
  logic [1:0]    stat;
  logic [1:0]    mask;

  // Bus pipeline state
  logic          apWr;
  logic          rdPend;
  logic [7:0]    apAddr;
  logic          addrPhase;

  // Engine state
  pcrc_eng_e     state;
  pcrc_word_t    word;
  pcrc_len_t     bitIdx;
  logic [CW-1:0] cntPrev;

  // Combinational nets
  logic          wrCon1;
  logic          wrCon2;
  logic          wrPolyL;
  logic          wrPolyH;
  logic          wrDatL;
  logic          wrDatH;
  logic          wrResL;
  logic          wrResH;
  logic          wrStat;
  logic          wrMask;
  logic          canPop;
  logic          finish;
  logic          lastBit;
  logic          dataBit;
  logic          cntZeroEv;
  logic          crcEv;
  logic          ovfEv;
  logic [1:0]    next_stat;
  logic          next_go;
  pcrc_len_t     startIdx;
  pcrc_word_t    resNext;
  pcrc_word_t    con1Rd;
  pcrc_word_t    rdMux;

  // Address phase taken only while the bus is ready
  assign addrPhase = hsel & htrans[1] & hready;

  // Write strobes land in the data phase with hwdata valid
  assign wrCon1  = apWr & (apAddr == `PCRC_OFF_CON1);
  assign wrCon2  = apWr & (apAddr == `PCRC_OFF_CON2);
  assign wrPolyL = apWr & (apAddr == `PCRC_OFF_POLYL);
  assign wrPolyH = apWr & (apAddr == `PCRC_OFF_POLYH);
  assign wrDatL  = apWr & (apAddr == `PCRC_OFF_DATL);
  assign wrDatH  = apWr & (apAddr == `PCRC_OFF_DATH);
  assign wrResL  = apWr & (apAddr == `PCRC_OFF_RESL);
  assign wrResH  = apWr & (apAddr == `PCRC_OFF_RESH);
  assign wrStat  = apWr & (apAddr == `PCRC_OFF_STAT);
  assign wrMask  = apWr & (apAddr == `PCRC_OFF_MASK);

  // Bus phase tracking; reads get one wait state so that a
  // write just before them is already visible
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      apWr      <= 1'b0;
      rdPend    <= 1'b0;
      apAddr    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      apWr      <= addrPhase & hwrite;
      rdPend    <= addrPhase & ~hwrite;
      apAddr    <= addrPhase ? haddr[7:0] : apAddr;
      hreadyout <= ~(addrPhase & ~hwrite);
      hresp     <= 1'b0;
    end
  end

  // Control register one readback with live FIFO status
  always_comb begin
    con1Rd                = `PCRC_WORD_ZERO;
    con1Rd[`PCRC_C1_EN]   = moduleEnableBit;
    con1Rd[`PCRC_C1_CNT]  = 5'(fif.count);
    con1Rd[`PCRC_C1_FULL] = fif.full;                           // [R11]
    con1Rd[`PCRC_C1_EMPTY]= fif.empty;
    con1Rd[`PCRC_C1_GO]   = calcGo;
    con1Rd[`PCRC_C1_LSB]  = lsbFirstSelect;
    con1Rd[`PCRC_C1_ISEL] = irqConditionSelect;
  end

  // Read mux; unmapped addresses read as zero
  assign rdMux =
    (apAddr == `PCRC_OFF_CON1)  ? con1Rd :
    (apAddr == `PCRC_OFF_CON2)  ? {19'h0, dataWordWidth, 3'h0, polyLength} :
    (apAddr == `PCRC_OFF_POLYL) ? {16'h0, polyTermsLow} :
    (apAddr == `PCRC_OFF_POLYH) ? {16'h0, polyTermsHigh} :
    (apAddr == `PCRC_OFF_DATL)  ? {16'h0, dataInLow} :
    (apAddr == `PCRC_OFF_DATH)  ? {16'h0, dataInHigh} :
    (apAddr == `PCRC_OFF_RESL)  ? {16'h0, result[`PCRC_HALF]} :      // [R16]
    (apAddr == `PCRC_OFF_RESH)  ? {16'h0, result[31:16]} :           // [R16]
    (apAddr == `PCRC_OFF_STAT)  ? {30'h0, stat} :
    (apAddr == `PCRC_OFF_MASK)  ? {30'h0, mask} : `PCRC_WORD_ZERO;

  // Read data is captured in the wait state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= `PCRC_WORD_ZERO;
    end else if (rdPend) begin
      hrdata <= rdMux;
    end
  end

  // Engine decisions; a disabled module neither pops nor finishes
  assign startIdx = lsbFirstSelect ? `PCRC_IDX_LOW : dataWordWidth;  // [R3]
  assign lastBit  = lsbFirstSelect ? (bitIdx == dataWordWidth)
                                   : (bitIdx == `PCRC_IDX_LOW);
  assign dataBit  = word[bitIdx];                                    // [R3] [R4]
  assign canPop   = moduleEnableBit & calcGo & (state == ENG_IDLE)
                    & ~fif.empty;                                    // [R13]
  assign finish   = moduleEnableBit & calcGo & (state == ENG_IDLE)
                    & fif.empty;                                     // [R15]

  // FIFO side: the high half write pushes the whole double word
  assign fif.push     = wrDatH & moduleEnableBit;                    // [R17]
  assign fif.pushData = {hwdata[`PCRC_HALF], dataInLow};             // [R17]
  assign fif.pop      = canPop;                                      // [R19]
  assign ovfEv        = wrDatH & moduleEnableBit & fif.full;         // [R11]

  pcrc_fifo #(
    .DEPTH (DEPTH),
    .CW    (CW)
  ) i_pcrc_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .flush    (~moduleEnableBit),
    .f        (fif)
  );

  pcrc_step i_pcrc_step (
    .rem  (result),
    .poly ({polyTermsHigh, polyTermsLow}),
    .poly_length (polyLength),
    .din  (dataBit),
    .nxt  (resNext)
  );

  // Interrupt events; select 1 counts finish, even when a control one write in that cycle overrides the go clear; select 0 the count going 1 to 0
  assign cntZeroEv = moduleEnableBit & (cntPrev == CW'(1))
                     & (fif.count == '0);                            // [R5]
  assign crcEv     = irqConditionSelect ? finish : cntZeroEv;        // [R5] [R6] [R7]
  assign next_stat = (stat & ~(wrStat ? hwdata[1:0] : 2'h0))
                     | {ovfEv, crcEv};

  // Software set of go wins over the hardware clear
  assign next_go = wrCon1 ? hwdata[`PCRC_C1_GO] : (calcGo & ~finish); // [R15]

  // Control register one and status flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      moduleEnableBit    <= 1'b0;
      calcGo             <= 1'b0;
      lsbFirstSelect     <= 1'b0;
      irqConditionSelect <= 1'b0;
      stat               <= '0;
      mask               <= '0;
      irq                <= 1'b0;
      cntPrev            <= '0;
    end else begin
      if (wrCon1) begin
        moduleEnableBit    <= hwdata[`PCRC_C1_EN];
        lsbFirstSelect     <= hwdata[`PCRC_C1_LSB];
        irqConditionSelect <= hwdata[`PCRC_C1_ISEL];
      end
      calcGo  <= next_go;
      stat    <= next_stat;
      mask    <= wrMask ? hwdata[1:0] : mask;
      irq     <= |(stat & mask);
      cntPrev <= fif.count;
    end
  end

  // Configuration and input holding registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataWordWidth <= `PCRC_DW_RST;
      polyLength    <= `PCRC_PL_RST;
      polyTermsLow  <= '0;
      polyTermsHigh <= '0;
      dataInLow     <= '0;
      dataInHigh    <= '0;
    end else begin
      if (wrCon2) begin
        dataWordWidth <= hwdata[`PCRC_C2_DW];                        // [R2]
        polyLength    <= hwdata[`PCRC_C2_PL];                        // [R1] [R2]
      end
      if (wrPolyL) polyTermsLow  <= hwdata[`PCRC_HALF];
      if (wrPolyH) polyTermsHigh <= hwdata[`PCRC_HALF];
      if (wrDatL)  dataInLow     <= hwdata[`PCRC_HALF];
      if (wrDatH)  dataInHigh    <= hwdata[`PCRC_HALF];
    end
  end

  // Result pair: the engine owns it while shifting, software
  // may load it when idle to clear or resume a remainder
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result <= `PCRC_WORD_ZERO;
    end else if (state == ENG_SHIFT) begin
      result <= resNext;                                             // [R18]
    end else begin
      if (wrResL) result[`PCRC_HALF] <= hwdata[`PCRC_HALF];          // [R12]
      if (wrResH) result[31:16]      <= hwdata[`PCRC_HALF];          // [R12]
    end
  end

  // Shift engine: one word at a time, dataWordWidth+1 bits per word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state  <= ENG_IDLE;
      word   <= `PCRC_WORD_ZERO;
      bitIdx <= '0;
    end else if (!moduleEnableBit) begin
      state  <= ENG_IDLE;
    end else begin
      case (state)
        ENG_IDLE: begin
          if (canPop) begin
            word   <= fif.popData;                                   // [R19]
            bitIdx <= startIdx;                                      // [R3]
            state  <= ENG_SHIFT;                                     // [R13]
          end
        end
        ENG_SHIFT: begin
          bitIdx <= lsbFirstSelect ? bitIdx + 5'h01 : bitIdx - 5'h01;
          if (lastBit) begin
            state <= ENG_IDLE;                                       // [R19]
          end
        end
        default: begin
          state <= ENG_IDLE;
        end
      endcase
    end
  end

  // Checks on the engine, the flags and the interrupt path
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_full_drop: assert property ( // [R11]
    wrDatH && moduleEnableBit && fif.full && !fif.pop
    |=> stat[`PCRC_S_OVF] && fif.count == $past(fif.count))
    else $error("Write into full FIFO was not dropped");

  a_go_start: assert property ( // [R13]
    canPop |=> state == ENG_SHIFT && word == $past(fif.popData))
    else $error("Go with data did not start the engine");

  a_start_order: assert property ( // [R3]
    canPop && lsbFirstSelect |=> bitIdx == `PCRC_IDX_LOW)
    else $error("LSB first word did not start at bit zero");

  a_word_bits: assert property ( // [R19]
    canPop && dataWordWidth == 5'h07 && !wrCon1 && !wrCon2
    |=> (state == ENG_SHIFT) [*8] ##1 state == ENG_IDLE)
    else $error("Eight bit word did not take eight shifts");

  a_go_hw_clear: assert property ( // [R15]
    finish && !wrCon1 |=> !calcGo)
    else $error("Go stayed set after completion");

  a_done_irq: assert property ( // [R6]
    finish && irqConditionSelect |=> stat[`PCRC_S_CRC] ##1 irq == mask[0])
    else $error("Completion interrupt missing");

  a_sw_clear_quiet: assert property ( // [R7]
    wrCon1 && !hwdata[`PCRC_C1_GO] && irqConditionSelect && !finish
    && !stat[`PCRC_S_CRC] |=> !stat[`PCRC_S_CRC])
    else $error("Software clear of go raised an interrupt");

  a_count_irq: assert property ( // [R5]
    !irqConditionSelect && moduleEnableBit && $past(fif.count) == CW'(1)
    && fif.count == '0 |=> stat[`PCRC_S_CRC])
    else $error("Count reaching zero raised no interrupt");

  a_feedback: assert property ( // [R18]
    state == ENG_SHIFT && polyLength == 5'h1f && !(dataBit ^ result[31])
    |=> result == ($past(result) << 1))
    else $error("Shift without feedback changed terms");

  a_result_clear: assert property ( // [R12]
    wrResL && state == ENG_IDLE |=> result[`PCRC_HALF] == $past(hwdata[15:0]))
    else $error("Result low write did not take");

  c_lsb_word: cover property (canPop && lsbFirstSelect ##1 state == ENG_SHIFT);
  c_done_irq: cover property (finish && irqConditionSelect ##2 irq);
  c_overflow: cover property (ovfEv);
  // Count-driven event and a software stop of a running job
  c_count_irq: cover property (cntZeroEv && !irqConditionSelect ##1 stat[`PCRC_S_CRC]);
  c_sw_stop:   cover property (wrCon1 && calcGo && !hwdata[`PCRC_C1_GO]);
endmodule : pcrc_top

/* pcrc_cfg.svh */
// Register map, field positions and reset values of the CRC engine
// Notes on behaviour
// R1: Polynomial of any length up to 32 bits
// R2: Data width and polynomial length set independently
// R3: MSB first by default, LSB first when selected
// R4: Bit order affects input only, result stays normal
// R5: Select 0: interrupt when word count goes 1 to 0
// R6: Select 1: interrupt when hardware clears go
// R7: Software clearing go raises no interrupt
// R8: Software enables module before using it
// R9: Software writes polynomial terms and length
// R10: Software sets width, order, interrupt select first
// R11: Full flag set; software preloads until full
// R12: Zeroed result restarts, kept result resumes
// R13: Setting go starts shifting FIFO data
// R14: Software refills FIFO while calculation runs
// R15: Hardware clears go when calculation completes
// R16: Remainder shown in low and high result
// R17: Input and result pairs are double-word buffers
// R18: Feedback is data bit XOR remainder top bit
// R19: Pop one word, shift width bits, count down
`ifndef PCRC_CFG_SVH
`define PCRC_CFG_SVH

`define PCRC_OFF_CON1  8'h00
`define PCRC_OFF_CON2  8'h04
`define PCRC_OFF_POLYL 8'h08
`define PCRC_OFF_POLYH 8'h0c
`define PCRC_OFF_DATL  8'h10
`define PCRC_OFF_DATH  8'h14
`define PCRC_OFF_RESL  8'h18
`define PCRC_OFF_RESH  8'h1c
`define PCRC_OFF_STAT  8'h20
`define PCRC_OFF_MASK  8'h24

`define PCRC_C1_EN     15
`define PCRC_C1_CNT    12:8
`define PCRC_C1_FULL   7
`define PCRC_C1_EMPTY  6
`define PCRC_C1_GO     4
`define PCRC_C1_LSB    3
`define PCRC_C1_ISEL   1
`define PCRC_C2_DW     12:8
`define PCRC_C2_PL     4:0
`define PCRC_HALF      15:0

`define PCRC_S_CRC     0
`define PCRC_S_OVF     1

`define PCRC_DW_RST    5'h1f
`define PCRC_PL_RST    5'h1f
`define PCRC_IDX_LOW   5'h00
`define PCRC_MASK_SEED 32'hffff_fffe
`define PCRC_WORD_ZERO 32'h0000_0000

`endif

/* pcrc_pkg.sv */
// Types shared by the CRC engine modules
package pcrc_pkg;
  typedef logic [31:0] pcrc_word_t;
  typedef logic [4:0]  pcrc_len_t;
  typedef enum logic {
    ENG_IDLE  = 1'b0,
    ENG_SHIFT = 1'b1
  } pcrc_eng_e;
endpackage : pcrc_pkg

/* pcrc_fifo_if.sv */
// Push and pop signals between the CRC core and its data FIFO
interface pcrc_fifo_if #(parameter int CW = 5);
  logic                 push;
  pcrc_pkg::pcrc_word_t pushData;
  logic                 pop;
  pcrc_pkg::pcrc_word_t popData;
  logic                 full;
  logic                 empty;
  logic [CW-1:0]        count;
  modport filler (output push, pushData, pop,
                  input popData, full, empty, count);
  modport store  (input push, pushData, pop,
                  output popData, full, empty, count);
endinterface : pcrc_fifo_if

/* pcrc_fifo.sv */
// Data FIFO holding input words for the shift engine
module pcrc_fifo #(
  parameter int DEPTH = 16,   // Power of two
  parameter int CW    = 5
) (
  input wire logic   core_clk,  // Clock
  input wire logic   rst,       // Async reset
  input wire logic   flush,     // Drop all words
  pcrc_fifo_if.store f          // Push and pop side
);
  import pcrc_pkg::*;
  localparam int PW = $clog2(DEPTH);

  pcrc_word_t    mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic          doPush;
  logic          doPop;

  // Push is refused when full, pop when empty
  assign doPush    = f.push & ~f.full;
  assign doPop     = f.pop & ~f.empty;
  assign f.full    = (count == CW'(DEPTH));
  assign f.empty   = (count == '0);
  assign f.count   = count;
  assign f.popData = mem[rdPtr];

  // Storage has no reset; only the pointers matter
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr] <= f.pushData;
    end
  end

  // Pointers and valid-word count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= wrPtr + PW'(doPush);
      rdPtr <= rdPtr + PW'(doPop);
      count <= count + CW'(doPush) - CW'(doPop);
    end
  end
endmodule : pcrc_fifo

/* pcrc_step.sv */
// One-bit step of the programmable CRC shift engine
`include "pcrc_cfg.svh"
module pcrc_step (
  input  wire logic [31:0] rem,   // Current remainder
  input  wire logic [31:0] poly,  // Polynomial terms
  input  wire logic [4:0]  poly_length,  // Length minus one
  input  wire logic        din,   // Data bit in
  output logic      [31:0] nxt    // Next remainder
);
  logic [31:0] lenMask;
  logic [31:0] shifted;
  logic        fb;

  // Bits above the programmed length stay zero
  assign lenMask = ~(`PCRC_MASK_SEED << poly_length);                   // [R1]
  assign fb      = din ^ rem[poly_length];                              // [R18]
  assign shifted = (rem << 1) & lenMask;
  assign nxt     = fb ? (shifted ^ (poly & lenMask)) : shifted;  // [R18]
endmodule : pcrc_step

/* pcrc_top_tb_top.sv */
// Self-checking testbench for the programmable CRC engine
`include "pcrc_cfg.svh"
module pcrc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pcrc_pkg::*;

  logic       core_clk;
  logic       rst;
  logic       hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic       hwrite;
  logic [2:0] hsize;
  pcrc_word_t hwdata;
  logic       hready;
  logic       hreadyout;
  pcrc_word_t hrdata;
  logic       hresp;
  logic       irq;
  pcrc_word_t ctlBase;
  int         errTotal;
  int         cmpCount;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pcrc_top #(.DEPTH(16), .CW(5)) i_pcrc_top (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq)
  );

  // Free-running 10 MHz clock
  always #50 core_clk = ~core_clk;

  task automatic chk(input pcrc_word_t seen, input pcrc_word_t exp, input string what);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input pcrc_word_t wd,
                      output pcrc_word_t rdv);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    rdv = hrdata;
    if (n >= 50) chk(32'h0, 32'h1, "bus wait ran out");
  endtask : xfer

  task automatic wr(input logic [7:0] a, input pcrc_word_t d);
    pcrc_word_t junk;
    xfer(1'b1, a, d, junk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output pcrc_word_t d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input pcrc_word_t exp, input string what);
    pcrc_word_t v;
    rd(a, v);
    chk(v, exp, what);
  endtask : rdchk

  // Low half first: the high write pushes the whole word
  task automatic push(input pcrc_word_t w);
    wr(`PCRC_OFF_DATL, {16'h0000, w[15:0]});
    wr(`PCRC_OFF_DATH, {16'h0000, w[31:16]});
  endtask : push

  // Bit-serial reference; only the input order depends on lsb
  function automatic pcrc_word_t crc_ref(input pcrc_word_t r, input pcrc_word_t poly,
                                         input int poly_length, input int w, input logic lsb,
                                         input pcrc_word_t d);
    logic fb;
    for (int i = 0; i < w; i++) begin
      fb = (lsb ? d[i] : d[w-1-i]) ^ r[poly_length];
      r = r << 1;
      if (fb) r = r ^ poly;
    end
    return (poly_length == 31) ? r : (r & ((32'h1 << (poly_length + 1)) - 32'h1));
  endfunction : crc_ref

  // Enable first, then shape, polynomial, mode, mask and a cleared result
  task automatic setup(input int poly_length, input int dw, input logic lsb, input logic isel,
                       input pcrc_word_t poly, input pcrc_word_t msk);
    ctlBase = 32'h0000_8000 | (lsb ? 32'h8 : 32'h0) | (isel ? 32'h2 : 32'h0);
    wr(`PCRC_OFF_CON1, 32'h0000_8000);
    wr(`PCRC_OFF_CON2, pcrc_word_t'(((dw - 1) << 8) | poly_length));
    wr(`PCRC_OFF_POLYL, {16'h0000, poly[15:0]});
    wr(`PCRC_OFF_POLYH, {16'h0000, poly[31:16]});
    wr(`PCRC_OFF_CON1, ctlBase);
    wr(`PCRC_OFF_MASK, msk);
    wr(`PCRC_OFF_STAT, 32'h0000_0003);
    wr(`PCRC_OFF_RESL, 32'h0000_0000);
    wr(`PCRC_OFF_RESH, 32'h0000_0000);
  endtask : setup

  // Start and poll the go bit under a bounded count
  task automatic run_wait();
    pcrc_word_t v;
    int n;
    n = 0;
    wr(`PCRC_OFF_CON1, ctlBase | 32'h0000_0010);
    do begin rd(`PCRC_OFF_CON1, v); n++; end while (v[4] !== 1'b0 && n < 300);
    chk(v, ctlBase | 32'h0000_0040, "control after finish");
  endtask : run_wait

  task automatic result(input pcrc_word_t exp, input string what);
    pcrc_word_t lo, hi;
    rd(`PCRC_OFF_RESL, lo);
    rd(`PCRC_OFF_RESH, hi);
    chk({hi[15:0], lo[15:0]}, exp, what);
  endtask : result

  // Status and line must agree, then a one-write clears both; the line
  // trails the status bit by a cycle, so it is looked at after the read
  task automatic irq_seen(input pcrc_word_t st, input logic lvl);
    rdchk(`PCRC_OFF_STAT, st, "status bits");
    chk({31'h0, irq}, {31'h0, lvl}, "irq level");
    wr(`PCRC_OFF_STAT, 32'h0000_0003);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
  endtask : irq_seen

  task automatic t_reset();
    rdchk(`PCRC_OFF_CON1, 32'h0000_0040, "control one reset");
    rdchk(`PCRC_OFF_CON2, 32'h0000_1f1f, "control two reset");
    rdchk(`PCRC_OFF_POLYH, 32'h0000_0000, "poly high reset");
    rdchk(`PCRC_OFF_RESL, 32'h0000_0000, "result low reset");
    rdchk(`PCRC_OFF_MASK, 32'h0000_0000, "mask reset");
    wr(8'h28, 32'hffff_ffff);
    rdchk(8'h28, 32'h0000_0000, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : t_reset

  // MSB first, 8-bit words under a 16-bit polynomial; junk above the width
  task automatic t_msb();
    pcrc_word_t e;
    setup(15, 8, 1'b0, 1'b1, 32'h0000_1021, 32'h0000_0001);
    e = 32'h0;
    for (int i = 0; i < 3; i++) begin
      push(32'h5a5a_a531 + i);
      e = crc_ref(e, 32'h1021, 15, 8, 1'b0, 32'h5a5a_a531 + i);
    end
    run_wait();
    result(e, "msb first crc");
    irq_seen(32'h0000_0001, 1'b1);
  endtask : t_msb

  // LSB first with full 32-bit width and polynomial: result not reflected;
  // the second word goes in while the first is still shifting
  task automatic t_lsb();
    pcrc_word_t e;
    setup(31, 32, 1'b1, 1'b1, 32'h04c1_1db7, 32'h0000_0001);
    push(32'h8000_0001);
    wr(`PCRC_OFF_CON1, ctlBase | 32'h0000_0010);
    push(32'h0f0f_3c3c);
    e = crc_ref(32'h0, 32'h04c1_1db7, 31, 32, 1'b1, 32'h8000_0001);
    e = crc_ref(e, 32'h04c1_1db7, 31, 32, 1'b1, 32'h0f0f_3c3c);
    run_wait();
    result(e, "lsb first crc");
    irq_seen(32'h0000_0001, 1'b1);
  endtask : t_lsb

  // Kept result resumes, zeroed result restarts; masked source leaves irq low
  task automatic t_resume();
    pcrc_word_t e;
    setup(15, 12, 1'b0, 1'b1, 32'h0000_8005, 32'h0000_0000);
    push(32'h0000_0abc);
    run_wait();
    e = crc_ref(32'h0, 32'h8005, 15, 12, 1'b0, 32'h0000_0abc);
    push(32'h0000_f123);
    run_wait();
    result(crc_ref(e, 32'h8005, 15, 12, 1'b0, 32'h0000_f123), "resumed crc");
    wr(`PCRC_OFF_RESL, 32'h0000_0000);
    wr(`PCRC_OFF_RESH, 32'h0000_0000);
    push(32'h0000_f123);
    run_wait();
    result(crc_ref(32'h0, 32'h8005, 15, 12, 1'b0, 32'h0000_f123), "restarted crc");
    irq_seen(32'h0000_0001, 1'b0);
  endtask : t_resume

  // Count-based interrupt, then a software stop of go
  task automatic t_isel();
    setup(7, 16, 1'b0, 1'b0, 32'h0000_0007, 32'h0000_0001);
    push(32'h0000_1234);
    push(32'h0000_8001);
    rdchk(`PCRC_OFF_STAT, 32'h0000_0000, "no event while filling");
    run_wait();
    result(crc_ref(crc_ref(32'h0, 32'h7, 7, 16, 1'b0, 32'h1234), 32'h7, 7, 16, 1'b0,
                   32'h8001), "16-bit words crc");
    irq_seen(32'h0000_0001, 1'b1);
    setup(31, 32, 1'b0, 1'b1, 32'h04c1_1db7, 32'h0000_0001);
    for (int i = 0; i < 4; i++) push(32'h1111_0000 + i);
    wr(`PCRC_OFF_CON1, ctlBase | 32'h0000_0010);
    wr(`PCRC_OFF_CON1, ctlBase);
    repeat (200) @(posedge core_clk);
    rdchk(`PCRC_OFF_STAT, 32'h0000_0000, "software stop raises nothing");
    chk({31'h0, irq}, 32'h0, "irq after software stop");
    wr(`PCRC_OFF_CON1, 32'h0000_0000);
  endtask : t_isel

  // Fill to full, overflow on one more, then disable flushes
  task automatic t_full();
    setup(31, 32, 1'b0, 1'b0, 32'h04c1_1db7, 32'h0000_0002);
    for (int i = 0; i < 15; i++) push(32'h2222_0000 + i);
    rdchk(`PCRC_OFF_CON1, ctlBase | 32'h0000_0f00, "fifteen words");
    push(32'h3333_3333);
    rdchk(`PCRC_OFF_CON1, ctlBase | 32'h0000_1080, "full flag");
    push(32'h4444_4444);
    irq_seen(32'h0000_0002, 1'b1);
    wr(`PCRC_OFF_CON1, 32'h0000_0000);
    rdchk(`PCRC_OFF_CON1, 32'h0000_0040, "flushed on disable");
    rdchk(`PCRC_OFF_STAT, 32'h0000_0000, "flush raises nothing");
  endtask : t_full

  task automatic closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : closeOut

  // Main sequence: reset for two cycles, then every scenario
  initial begin
    core_clk = 1'b0;
    rst      = 1'b1;
    hsel     = 1'b0;
    haddr    = 32'h0000_0000;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0000_0000;
    ctlBase  = 32'h0000_0000;
    errTotal = 0;
    cmpCount = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    t_reset();
    t_msb();
    t_lsb();
    t_resume();
    t_isel();
    t_full();
    closeOut();
  end

  // Watchdog: the scenarios need well under 20000 cycles
  initial begin
    #2_000_000;
    errTotal++;
    closeOut();
  end
endmodule : pcrc_top_tb_top
